// ### common/event_router_pkg.sv
package event_router_pkg;

	// ==========================================================
	// sizes
	localparam int unsigned NUM_EVENTS = 27;  // event codes 0x00..0x1a
	localparam int unsigned SEL_W      = 6;
	localparam int unsigned NUM_DEST   = 6;
	localparam int unsigned PORT_W     = 16;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned STRB_W     = 4;

	// ==========================================================
	// destination slots
	localparam int unsigned DEST_CONV  = 0;
	localparam int unsigned DEST_TMR0  = 1;
	localparam int unsigned DEST_TMR1  = 2;
	localparam int unsigned DEST_PORT1 = 3;
	localparam int unsigned DEST_PORT2 = 4;
	localparam int unsigned DEST_ITV   = 5;

	// ==========================================================
	// router-owned event codes
	localparam int unsigned EVT_SW0 = 20;  // 0x14
	localparam int unsigned EVT_SW1 = 21;  // 0x15
	localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;

	// ==========================================================
	// latencies in core clock cycles, event rise to output rise
	localparam int unsigned LAT_CONV      = 4;
	localparam int unsigned LAT_TMR       = 4;
	localparam int unsigned LAT_PORT_EVT  = 2;  // pins change one later
	localparam int unsigned LAT_PORT_PIN  = 3;

	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SWEVT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SEL0    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SEL_END = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_P1_SET  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_P1_RST  = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_P2_SET  = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_P2_RST  = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_P1_DATA = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_P2_DATA = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h38;

	// ==========================================================
	// field positions and reset values
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned SW0_BIT       = 0;
	localparam int unsigned SW1_BIT       = 1;
	localparam int unsigned STAT_STOP_BIT = 0;
	localparam int unsigned STAT_AV_LSB   = 1;
	localparam logic [PORT_W-1:0] PORT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] ZERO32   = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/event_router.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
module event_router (
	input  wire logic                                     aclk,
	input  wire logic                                     aresetn,
	// axi4-lite slave
	input  wire logic [event_router_pkg::ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                                     s_axi_awvalid,
	output logic                                          s_axi_awready,
	input  wire logic [event_router_pkg::DATA_W-1:0]      s_axi_wdata,
	input  wire logic [event_router_pkg::STRB_W-1:0]      s_axi_wstrb,
	input  wire logic                                     s_axi_wvalid,
	output logic                                          s_axi_wready,
	output logic [1:0]                                    s_axi_bresp,
	output logic                                          s_axi_bvalid,
	input  wire logic                                     s_axi_bready,
	input  wire logic [event_router_pkg::ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                                     s_axi_arvalid,
	output logic                                          s_axi_arready,
	output logic [event_router_pkg::DATA_W-1:0]           s_axi_rdata,
	output logic [1:0]                                    s_axi_rresp,
	output logic                                          s_axi_rvalid,
	input  wire logic                                     s_axi_rready,
	// system state
	input  wire logic                                     module_stop_control_c,
	input  wire logic [event_router_pkg::NUM_DEST-1:0]    dest_module_stop,
	input  wire logic                                     standby_mode,
	input  wire logic                                     snooze_mode,
	input  wire logic                                     converter_active,
	input  wire logic                                     transfer_active,
	input  wire logic                                     serial_active,
	// event sources, bit n is event code n
	input  wire logic [event_router_pkg::NUM_EVENTS-1:0]  event_in,
	// destinations
	output logic                                          converter_link_event,
	output logic                                          timer_ch0_link_event,
	output logic                                          timer_ch1_link_event,
	output logic                                          port1_link_event,
	output logic                                          port2_link_event,
	output logic                                          interval_timer_link_event,
	output logic [event_router_pkg::PORT_W-1:0]           port1_pin_out,
	output logic [event_router_pkg::PORT_W-1:0]           port2_pin_out
);

	localparam int unsigned ND = event_router_pkg::NUM_DEST;
	localparam int unsigned PW = event_router_pkg::PORT_W;

	// ==========================================================
	// control state
	logic                              stop_q;
	logic                              enable_q;
	logic [1:0]                        sw_q;
	logic [event_router_pkg::SEL_W-1:0] sel_q [ND];
	logic [PW-1:0]                     p1_set_q;
	logic [PW-1:0]                     p1_rst_q;
	logic [PW-1:0]                     p2_set_q;
	logic [PW-1:0]                     p2_rst_q;
	logic [PW-1:0]                     p1_pin_q;
	logic [PW-1:0]                     p2_pin_q;

	// ==========================================================
	// bus slave state
	logic                              aw_hold_q;
	logic                              w_hold_q;
	logic                              aw_hold_d;
	logic                              w_hold_d;
	logic [event_router_pkg::ADDR_W-1:0] waddr_q;
	logic [event_router_pkg::DATA_W-1:0] wdata_q;
	logic [event_router_pkg::STRB_W-1:0] wstrb_q;
	logic                              wr_fire;
	logic                              rd_fire;
	logic                              rvalid_d;
	logic                              awready_q;
	logic                              wready_q;
	logic                              bvalid_q;
	logic [1:0]                        bresp_q;
	logic                              arready_q;
	logic                              rvalid_q;
	logic [1:0]                        rresp_q;
	logic [event_router_pkg::DATA_W-1:0] rdata_q;
	logic [event_router_pkg::DATA_W-1:0] wmask;
	logic                              wr_ok;
	logic                              wr_mapped;

	// ==========================================================
	// routing state
	logic [event_router_pkg::NUM_EVENTS-1:0] src_now;
	logic [event_router_pkg::NUM_EVENTS-1:0] src_q;
	logic [event_router_pkg::NUM_EVENTS-1:0] src_edge;
	logic [ND-1:0]                     hit;
	logic [ND-1:0]                     avail;
	logic [ND-1:0]                     fire;
	logic [ND-1:0]                     dest_out;

	// byte lanes to bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// ==========================================================
	// module stop: held stopped through reset, then follows the control
	always_ff @(posedge aclk) begin
		if (!aresetn)
			stop_q <= 1'b1;
		else
			stop_q <= module_stop_control_c;
	end

	// ==========================================================
	// write channel: address and data taken in either order
	assign wr_fire   = aw_hold_q && w_hold_q && !bvalid_q;
	assign aw_hold_d = (aw_hold_q || (s_axi_awvalid && awready_q)) && !wr_fire;
	assign w_hold_d  = (w_hold_q || (s_axi_wvalid && wready_q)) && !wr_fire;
	assign wmask     = lane_mask(wstrb_q);
	// registers are closed while stopped
	assign wr_ok     = wr_fire && !stop_q;

	always_comb begin
		wr_mapped = 1'b0;
		if (waddr_q[1:0] == 2'h0 && waddr_q <= event_router_pkg::OFS_STATUS)
			wr_mapped = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			waddr_q   <= '0;
			wdata_q   <= event_router_pkg::ZERO32;
			wstrb_q   <= '0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awready_q <= !aw_hold_d;
			wready_q  <= !w_hold_d;
			if (s_axi_awvalid && awready_q)
				waddr_q <= s_axi_awaddr;
			if (s_axi_wvalid && wready_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= event_router_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (stop_q || !wr_mapped) ?
				event_router_pkg::RESP_SLVERR : event_router_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// control and software event registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q <= 1'b0;
			sw_q     <= 2'h0;
		end else begin
			sw_q <= 2'h0;  // software events are one-cycle pulses
			if (wr_ok && wstrb_q[0]) begin
				if (waddr_q == event_router_pkg::OFS_CTRL)
					enable_q <= wdata_q[event_router_pkg::CTRL_EN_BIT];
				if (waddr_q == event_router_pkg::OFS_SWEVT)
					sw_q <= {wdata_q[event_router_pkg::SW1_BIT],
					         wdata_q[event_router_pkg::SW0_BIT]};
			end
		end
	end

	// selectors, one word each; only the low byte holds a field
	generate
		for (genvar i = 0; i < ND; i++) begin : g_sel
			localparam logic [event_router_pkg::ADDR_W-1:0] OFS =
				event_router_pkg::OFS_SEL0 + 8'(4 * i);
			always_ff @(posedge aclk) begin
				if (!aresetn)
					sel_q[i] <= event_router_pkg::SEL_NONE;
				else if (wr_ok && wstrb_q[0] && waddr_q == OFS)
					sel_q[i] <= wdata_q[event_router_pkg::SEL_W-1:0];
			end
		end
	endgenerate

	// port set and reset masks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p1_set_q <= event_router_pkg::PORT_RST;
			p1_rst_q <= event_router_pkg::PORT_RST;
			p2_set_q <= event_router_pkg::PORT_RST;
			p2_rst_q <= event_router_pkg::PORT_RST;
		end else if (wr_ok) begin
			unique case (waddr_q)
				event_router_pkg::OFS_P1_SET:
					p1_set_q <= PW'((p1_set_q & ~wmask) | (wdata_q & wmask));
				event_router_pkg::OFS_P1_RST:
					p1_rst_q <= PW'((p1_rst_q & ~wmask) | (wdata_q & wmask));
				event_router_pkg::OFS_P2_SET:
					p2_set_q <= PW'((p2_set_q & ~wmask) | (wdata_q & wmask));
				event_router_pkg::OFS_P2_RST:
					p2_rst_q <= PW'((p2_rst_q & ~wmask) | (wdata_q & wmask));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// read channel, data registered at the accepting edge
	assign rd_fire  = s_axi_arvalid && arready_q;
	assign rvalid_d = (rvalid_q && !s_axi_rready) || rd_fire;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= event_router_pkg::RESP_OKAY;
			rdata_q   <= event_router_pkg::ZERO32;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q  <= rvalid_d;
			if (rd_fire) begin
				rdata_q <= event_router_pkg::ZERO32;
				rresp_q <= event_router_pkg::RESP_OKAY;
				if (stop_q) begin
					rresp_q <= event_router_pkg::RESP_SLVERR;
				end else if (s_axi_araddr >= event_router_pkg::OFS_SEL0 &&
				             s_axi_araddr <= event_router_pkg::OFS_SEL_END &&
				             s_axi_araddr[1:0] == 2'h0) begin
					rdata_q <= 32'(sel_q[3'((s_axi_araddr -
						event_router_pkg::OFS_SEL0) >> 2)]);
				end else begin
					unique case (s_axi_araddr)
						event_router_pkg::OFS_CTRL:    rdata_q <= 32'(enable_q);
						event_router_pkg::OFS_SWEVT:   ;  // reads as zero
						event_router_pkg::OFS_P1_SET:  rdata_q <= 32'(p1_set_q);
						event_router_pkg::OFS_P1_RST:  rdata_q <= 32'(p1_rst_q);
						event_router_pkg::OFS_P2_SET:  rdata_q <= 32'(p2_set_q);
						event_router_pkg::OFS_P2_RST:  rdata_q <= 32'(p2_rst_q);
						event_router_pkg::OFS_P1_DATA: rdata_q <= 32'(p1_pin_q);
						event_router_pkg::OFS_P2_DATA: rdata_q <= 32'(p2_pin_q);
						event_router_pkg::OFS_STATUS:
							rdata_q <= 32'({avail, stop_q});
						default: rresp_q <= event_router_pkg::RESP_SLVERR;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// sources: core clock logic, so no synchroniser; the router's own
	// software events take their code slots, code zero is never an event
	always_comb begin
		src_now = event_in;
		src_now[0] = 1'b0;
		src_now[event_router_pkg::EVT_SW0] = sw_q[0];
		src_now[event_router_pkg::EVT_SW1] = sw_q[1];
	end

	// rising edges only, so a held source gives one routed pulse
	always_ff @(posedge aclk) begin
		if (!aresetn)
			src_q <= '0;
		else
			src_q <= src_now;
	end
	assign src_edge = src_now & ~src_q;

	// ==========================================================
	// availability per destination in the current power state
	always_comb begin  // snooze gates ports only
		for (int unsigned i = 0; i < ND; i++) begin
			avail[i] = !dest_module_stop[i] && !stop_q;
			if (standby_mode && i != event_router_pkg::DEST_ITV)
				avail[i] = 1'b0;
			if (snooze_mode && (i == event_router_pkg::DEST_PORT1 ||
			                    i == event_router_pkg::DEST_PORT2) &&
			    !(converter_active || transfer_active || serial_active))
				avail[i] = 1'b0;
		end
	end

	// ==========================================================
	// per destination: select, gate, delay all but the interval timer
	generate
		for (genvar i = 0; i < ND; i++) begin : g_dest
			source_mux u_mux (
				.events (src_edge),
				.sel    (sel_q[i]),
				.hit    (hit[i])
			);
			// enable gates all destinations together
			assign fire[i] = hit[i] && enable_q && avail[i];
			if (i == event_router_pkg::DEST_ITV) begin : g_comb
				// no register: the timer must see it in the same cycle
				assign dest_out[i] = fire[i];
			end else begin : g_pipe
				link_delay #(
					.DEPTH ((i == event_router_pkg::DEST_CONV) ?
					        event_router_pkg::LAT_CONV :
					        (i == event_router_pkg::DEST_TMR0 ||
					         i == event_router_pkg::DEST_TMR1) ?
					        event_router_pkg::LAT_TMR :
					        event_router_pkg::LAT_PORT_EVT)
				) u_dly (
					.aclk      (aclk),
					.aresetn   (aresetn),
					.pulse_in  (fire[i]),
					.pulse_out (dest_out[i])
				);
			end
		end
	endgenerate

	// ==========================================================
	// port groups: reset mask clears, set mask wins on overlap;
	// an event beats a software write to the data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p1_pin_q <= event_router_pkg::PORT_RST;
			p2_pin_q <= event_router_pkg::PORT_RST;
		end else begin
			if (dest_out[event_router_pkg::DEST_PORT1])
				p1_pin_q <= (p1_pin_q & ~p1_rst_q) | p1_set_q;
			else if (wr_ok && waddr_q == event_router_pkg::OFS_P1_DATA)
				p1_pin_q <= PW'((p1_pin_q & ~wmask) | (wdata_q & wmask));
			if (dest_out[event_router_pkg::DEST_PORT2])
				p2_pin_q <= (p2_pin_q & ~p2_rst_q) | p2_set_q;
			else if (wr_ok && waddr_q == event_router_pkg::OFS_P2_DATA)
				p2_pin_q <= PW'((p2_pin_q & ~wmask) | (wdata_q & wmask));
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	assign converter_link_event      = dest_out[event_router_pkg::DEST_CONV];
	assign timer_ch0_link_event      = dest_out[event_router_pkg::DEST_TMR0];
	assign timer_ch1_link_event      = dest_out[event_router_pkg::DEST_TMR1];
	assign port1_link_event          = dest_out[event_router_pkg::DEST_PORT1];
	assign port2_link_event          = dest_out[event_router_pkg::DEST_PORT2];
	assign interval_timer_link_event = dest_out[event_router_pkg::DEST_ITV];
	assign port1_pin_out             = p1_pin_q;
	assign port2_pin_out             = p2_pin_q;

endmodule

// ### src/link_delay.sv
// ==========================================================
// fixed pipeline that delays a routed pulse by its latency
module link_delay #(
	parameter int unsigned DEPTH = 1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pulse_in,
	output logic      pulse_out
);

	logic [DEPTH-1:0] stage_q;

	// plain shift; pulse width is preserved end to end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			stage_q <= '0;
		else
			stage_q <= DEPTH'({stage_q, pulse_in});  // oldest bit drops out
	end

	assign pulse_out = stage_q[DEPTH-1];

endmodule

// ### src/source_mux.sv
// ==========================================================
// picks the event named by a selector; zero or codes past the
// table select nothing
module source_mux (
	input  wire logic [event_router_pkg::NUM_EVENTS-1:0] events,
	input  wire logic [event_router_pkg::SEL_W-1:0]      sel,
	output logic                                         hit
);

	// selector decode, out-of-range codes never hit
	always_comb begin
		hit = 1'b0;
		for (int unsigned k = 1; k < event_router_pkg::NUM_EVENTS; k++) begin
			if (sel == k[event_router_pkg::SEL_W-1:0])
				hit = events[k];
		end
	end

endmodule

// ### tb/event_peers.sv
// ==========================================================
// source and destination peripherals around the router
module event_peers (
	input  wire logic                               aclk,
	input  wire logic                               fire,
	input  wire logic [4:0]                         code,
	input  wire logic [5:0]                         dest,
	output logic [event_router_pkg::NUM_EVENTS-1:0] event_in,
	output logic [5:0]                              hit_q,
	output logic [5:0][7:0]                         lat_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]                              cyc_q = 8'h00;
	logic [7:0]                              t0_q = 8'h00;
	logic [event_router_pkg::NUM_EVENTS-1:0] ev_q = '0;
	initial hit_q = 6'h00;
	initial lat_q = '0;
	assign event_in = ev_q;
	// one-cycle source pulse, low again so the next shot rises
	always @(posedge aclk) begin
		cyc_q <= cyc_q + 8'h01;
		ev_q <= '0;  // no code aimed back at its maker
		if (fire) begin
			ev_q[code] <= 1'b1;
			t0_q <= cyc_q;
			hit_q <= 6'h00;
		end
		// arrival logged one edge late, so subtract that edge
		for (int i = 0; i < 6; i++) begin
			if (dest[i] && !fire) begin
				hit_q[i] <= 1'b1;
				lat_q[i] <= cyc_q - t0_q - 8'h01;  // no filter
			end
		end
	end
endmodule

// ### tb/event_router_asserts.sv
// ==========================================================
// port-level checks on the event router
module event_router_asserts (
	input wire logic                                        aclk,
	input wire logic                                        aresetn,
	input wire logic                                        s_axi_bvalid,
	input wire logic [1:0]                                  s_axi_bresp,
	input wire logic                                        s_axi_rvalid,
	input wire logic [1:0]                                  s_axi_rresp,
	input wire logic [event_router_pkg::DATA_W-1:0]         s_axi_rdata,
	input wire logic                                        module_stop_control_c,
	input wire logic                                        standby_mode,
	input wire logic [event_router_pkg::NUM_EVENTS-1:0]     event_in,
	input wire logic                                        converter_link_event,
	input wire logic                                        timer_ch0_link_event,
	input wire logic                                        timer_ch1_link_event,
	input wire logic                                        port1_link_event,
	input wire logic                                        port2_link_event,
	input wire logic                                        interval_timer_link_event,
	input wire logic [event_router_pkg::PORT_W-1:0]         port1_pin_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// stopped router: bus refused, interval link quiet
	sequence stopped_s;
		module_stop_control_c [*4];
	endsequence
	a_stop_wr_err: assert property (
		(stopped_s ##0 $rose(s_axi_bvalid)) |->
		s_axi_bresp == event_router_pkg::RESP_SLVERR)
		else $error("write to stopped router not refused");
	a_stop_rd_err: assert property (
		(stopped_s ##0 $rose(s_axi_rvalid)) |->
		s_axi_rresp == event_router_pkg::RESP_SLVERR && s_axi_rdata == '0)
		else $error("read of stopped router not refused");
	a_stop_itv_quiet: assert property (
		module_stop_control_c [*2] |-> !interval_timer_link_event)
		else $error("interval link while router stopped");
	// standby holds long enough to flush the pipelines first
	a_standby_quiet: assert property (
		standby_mode [*8] |-> !(converter_link_event | timer_ch0_link_event
		| timer_ch1_link_event | port1_link_event | port2_link_event))
		else $error("routed pulse in standby");
	// ==========================================================
	// pulse shapes; software events come with the write response up
	a_itv_from_event: assert property (
		interval_timer_link_event |-> (|event_in) || s_axi_bvalid)
		else $error("interval link without a source event");
	a_conv_one_wide: assert property (
		converter_link_event |=> !converter_link_event)
		else $error("converter trigger wider than a cycle");
	a_tmr0_fall_next: assert property (
		$rose(timer_ch0_link_event) |=> $fell(timer_ch0_link_event))
		else $error("timer ch0 falling edge late");
	a_tmr1_fall_next: assert property (
		$rose(timer_ch1_link_event) |=> $fell(timer_ch1_link_event))
		else $error("timer ch1 falling edge late");
	a_port_one_wide: assert property (
		port1_link_event |=> !port1_link_event)
		else $error("port link pulse wider than a cycle");
	a_reset_quiet: assert property (
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& port1_pin_out == '0 && !converter_link_event)
		else $error("outputs not idle after reset");
endmodule
bind event_router event_router_asserts chk_u (.*);

// ### tb/testbench.sv
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
	fails++; $display("CHECK FAILED %0t %s", $time, msg); end end
// ==========================================================
// bench top: bus tasks, event shots, verdict
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic [7:0]       s_axi_awaddr = 8'h00;
	logic [7:0]       s_axi_araddr = 8'h00;
	logic [31:0]      s_axi_wdata = 32'h0000_0000;
	logic [3:0]       s_axi_wstrb = 4'hf;
	logic             s_axi_awvalid = 1'b0;
	logic             s_axi_wvalid = 1'b0;
	logic             s_axi_arvalid = 1'b0;
	logic             s_axi_bready = 1'b1;
	logic             s_axi_rready = 1'b1;
	logic             module_stop_control_c = 1'b1;
	logic [5:0]       dest_module_stop = 6'h00;
	logic             standby_mode = 1'b0;
	logic             snooze_mode = 1'b0;
	logic             converter_active = 1'b0;
	logic             transfer_active = 1'b0;
	logic             serial_active = 1'b0;
	logic             fire = 1'b0;
	logic [4:0]       code = 5'h00;
	logic [26:0]      event_in;
	logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic             s_axi_arready, s_axi_rvalid;
	logic [1:0]       s_axi_bresp, s_axi_rresp;
	logic [31:0]      s_axi_rdata;
	logic             converter_link_event, timer_ch0_link_event;
	logic             timer_ch1_link_event, port1_link_event;
	logic             port2_link_event, interval_timer_link_event;
	logic [15:0]      port1_pin_out, port2_pin_out;
	logic [5:0]       hit;
	logic [5:0][7:0]  lat;
	logic [7:0]       exp_lat [6] = '{8'h04, 8'h04, 8'h04, 8'h02, 8'h02, 8'h00};
	int               fails = 0;
	int               total_checks = 0;
	int               cyc = 0;
	event_router dut_u (.*);
	event_peers peers_u (
		.aclk     (aclk),
		.fire     (fire),
		.code     (code),
		.dest     ({interval_timer_link_event, port2_link_event,
			port1_link_event, timer_ch1_link_event,
			timer_ch0_link_event, converter_link_event}),
		.event_in (event_in),
		.hit_q    (hit),
		.lat_q    (lat)
	);
	always #10 aclk = ~aclk;
	// hang guard: the run needs a few hundred cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	// ==========================================================
	// bus tasks: hold each channel until its ready is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		`CHK(s_axi_bresp, e ? 2'h2 : 2'h0, "write response")
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input bit e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		`CHK(s_axi_rdata, d, "read data")
		`CHK(s_axi_rresp, e ? 2'h2 : 2'h0, "read response")
	endtask
	// one source pulse, then see which destinations answered
	task automatic shoot(input logic [4:0] c, input logic [5:0] h);
		code <= c;
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (8) @(posedge aclk);
		`CHK(hit, h, "routed destinations")
	endtask
	task automatic summarize();
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wr(8'h00, 32'h0000_0001, 1'b1);
		rd(8'h38, 32'h0000_0000, 1'b1);
		module_stop_control_c <= 1'b0;
		repeat (2) @(posedge aclk);
		rd(8'h00, 32'h0000_0000, 1'b0);
		rd(8'h08, 32'h0000_0000, 1'b0);
		rd(8'h3c, 32'h0000_0000, 1'b1);
		rd(8'h38, 32'h0000_007e, 1'b0);
		for (int i = 0; i < 6; i++)
			wr(8'h08 + 8'(4 * i), 32'(i + 1), 1'b0);
		wr(8'h00, 32'h0000_0001, 1'b0);
		for (int i = 0; i < 6; i++) begin
			shoot(5'(i + 1), 6'h01 << i);
			`CHK(lat[i], exp_lat[i], "latency")
		end
		wr(8'h00, 32'h0000_0000, 1'b0);
		shoot(5'h06, 6'h00);
		wr(8'h20, 32'h0000_00f0, 1'b0);
		wr(8'h24, 32'h0000_000f, 1'b0);
		wr(8'h28, 32'h0000_0003, 1'b0);
		wr(8'h30, 32'h0000_0f0f, 1'b0);
		wr(8'h00, 32'h0000_0001, 1'b0);
		shoot(5'h04, 6'h08);
		`CHK(port1_pin_out, 16'h0ff0, "port set and reset")
		dest_module_stop <= 6'h02;
		shoot(5'h02, 6'h00);
		dest_module_stop <= 6'h00;
		standby_mode <= 1'b1;
		shoot(5'h04, 6'h00);
		shoot(5'h06, 6'h20);
		standby_mode <= 1'b0;
		snooze_mode <= 1'b1;
		shoot(5'h05, 6'h00);
		// snooze shots aim at port 2 only, never converter or timers
		for (int j = 0; j < 3; j++) begin
			{converter_active, transfer_active, serial_active} <= 3'b001 << j;
			shoot(5'h05, 6'h10);
		end
		`CHK(port2_pin_out, 16'h0003, "port2 set")
		snooze_mode <= 1'b0;
		wr(8'h00, 32'h0000_0000, 1'b0);
		wr(8'h08, 32'h0000_0000, 1'b0);
		wr(8'h00, 32'h0000_0001, 1'b0);
		shoot(5'h01, 6'h00);
		shoot(5'h02, 6'h02);
		wr(8'h00, 32'h0000_0000, 1'b0);
		// software event 0 into port 1, selector changed while disabled
		wr(8'h14, 32'h0000_0014, 1'b0);
		wr(8'h30, 32'h0000_000f, 1'b0);
		wr(8'h00, 32'h0000_0001, 1'b0);
		wr(8'h04, 32'h0000_0001, 1'b0);
		repeat (4) @(posedge aclk);
		`CHK(port1_pin_out, 16'h00f0, "software event")
		wr(8'h00, 32'h0000_0000, 1'b0);
		module_stop_control_c <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(8'h0c, 32'h0000_0000, 1'b1);
		summarize();
	end
endmodule
